/* rtl/byte_op_pkg.sv */
// Package for the byte-op execute unit: opcodes, field layout, timing.
// Assumes a 14-bit instruction word and an 8-bit data path.
package byte_op_pkg;
    localparam int INSTR_W       = 14;
    localparam int DATA_W        = 8;
    localparam int FADDR_W       = 7;
    localparam int PC_W          = 13;
    localparam int JUMP_W        = 11;
    localparam int BIT_SEL_W     = 3;
    localparam int OSC_PER_CYCLE = 4;
    localparam int PHASE_W       = 2;
    localparam int FILE_DEPTH    = 128;

    // Field positions inside the instruction word
    localparam int DEST_BIT      = 7;
    localparam int FADDR_LSB     = 0;
    localparam int BITSEL_LSB    = 7;
    localparam int JUMP_LSB      = 0;
    localparam int PAGE_LO       = 3;

    // Byte-op opcodes, bits 13..8
    localparam logic [5:0] OP_COMPLEMENT = 6'h09;
    localparam logic [5:0] OP_DECREMENT  = 6'h03;
    localparam logic [5:0] OP_INCREMENT  = 6'h0A;
    localparam logic [5:0] OP_DEC_SKIP   = 6'h0B;
    localparam logic [5:0] OP_INC_SKIP   = 6'h0F;
    // Long jump: bits 13..11
    localparam logic [2:0] OP_LONG_JUMP  = 3'h5;

    localparam logic [7:0]  W_RESET      = 8'h00;
    localparam logic [PC_W-1:0] PC_RESET = 13'h0000;
    localparam logic [1:0]  PHASE_RESET  = 2'h0;

    typedef enum logic [1:0] {
        ST_FETCH = 2'b00,
        ST_NOP   = 2'b01
    } exec_state_e;

    typedef struct packed {
        logic [5:0]         opcode;
        logic               dest_file;
        logic [FADDR_W-1:0] faddr;
        logic [BIT_SEL_W-1:0] bit_sel;
        logic [JUMP_W-1:0]  jump_target;
    } decoded_s;

    typedef struct packed {
        logic               z_write;
        logic               z_value;
        logic               w_write;
        logic               f_write;
        logic [DATA_W-1:0]  result;
    } result_s;
endpackage

/* rtl/file_ram.sv */
// Small file-register memory with registered read data.
// Assumes one write and one read port on the same clock.
`timescale 1ns/1ps
`default_nettype none
module file_ram
    import byte_op_pkg::*;
#(
    parameter int DEPTH  = FILE_DEPTH,
    parameter int AW     = FADDR_W,
    parameter int DW     = DATA_W
) (
    input  wire logic          ref_clk,  // Core clock
    input  wire logic          wr_en,    // Write strobe
    input  wire logic [AW-1:0] wr_addr,  // Write address
    input  wire logic [DW-1:0] wr_data,  // Write data
    input  wire logic [AW-1:0] rd_addr,  // Read address
    output logic      [DW-1:0] rd_data   // Registered read data
);
    logic [DW-1:0] mem [DEPTH];

    always_ff @(posedge ref_clk) begin
        if (wr_en) begin
            mem[wr_addr] <= wr_data;
        end
        rd_data <= mem[rd_addr];
    end
endmodule
`default_nettype wire

/* rtl/byte_op_execute_unit.sv */
// Execute unit for complement/decrement/increment of a file register,
// the skip-on-null variants and the long jump.
// Assumes instr arrives before phase 0 of each cycle; ref_clk is the osc.
// Assumes instr holds for all four phases of the cycle it is meant for.
// The file RAM has no reset: its words are unknown until written.
// Words presented during a flushed cycle are dropped.
// Functional notes
// - One cycle per instruction; jump or taken skip adds NOP
// - Instruction cycle is four oscillator periods
// - Destination bit: 0 accumulator, 1 file
// - Bit field selects one of eight bits
// - Complement inverts register, updates zero only
// - Long jump: immediate low, latch bits high
// - Decrement subtracts one, updates zero only
// - Increment adds one, updates zero only
// - Decrement-skip: no status, NOP on zero
// - Increment-skip: no status, NOP on zero
// - File address field is seven bits
`timescale 1ns/1ps
`default_nettype none
module byte_op_execute_unit
    import byte_op_pkg::*;
(
    input  wire logic               ref_clk,        // Oscillator clock
    input  wire logic               reset,          // Sync reset, high
    input  wire logic [INSTR_W-1:0] instr,          // Current instruction
    input  wire logic [7:0]         pc_upper_page_latch, // Page latch
    output logic      [PC_W-1:0]    pc,             // Program counter
    output logic      [DATA_W-1:0]  acc,            // Accumulator
    output logic                    zero_flag,      // Zero status
    output logic      [1:0]         phase,          // Oscillator phase
    output logic                    cycle_end,      // Last phase pulse
    output logic                    nop_cycle,      // Flushed cycle
    output logic                    unknown_op,     // Not decoded here
    output logic                    sel_bit,        // Bit-select operand
    output logic      [DATA_W-1:0]  file_rd_data    // Operand read
);
    logic [1:0]         phase_r;
    logic [1:0]         phase_nxt;
    exec_state_e        state_r;
    exec_state_e        state_nxt;
    logic [PC_W-1:0]    pc_r;
    logic [PC_W-1:0]    pc_nxt;
    logic [DATA_W-1:0]  acc_r;
    logic               zero_r;
    decoded_s           dec;
    result_s            res;
    logic [DATA_W-1:0]  operand;
    logic               is_com;
    logic               is_dec;
    logic               is_inc;
    logic               is_decsz;
    logic               is_incsz;
    logic               is_jump;
    logic               result_zero;
    logic               take_skip;
    logic               exec_strobe;
    logic               in_fetch;
    logic               in_nop;
    logic               dest_acc;

    logic [DATA_W-1:0]  com_val;
    logic [DATA_W-1:0]  dec_val;
    logic [DATA_W-1:0]  inc_val;
    logic [DATA_W-1:0]  alu_out;
    logic [PC_W-1:0]    jump_pc;
    logic [PC_W-1:0]    step_pc;
    logic [PC_W-1:0]    skip_pc;
    logic [DATA_W-1:0]  bit_hit;

    // Four oscillator periods per instruction cycle
    assign phase_nxt   = phase_r + 2'h1;
    // Execution happens on the edge that closes the last phase
    assign exec_strobe = (phase_r == 2'(OSC_PER_CYCLE - 1));
    assign in_fetch    = (state_r == ST_FETCH);
    assign in_nop      = (state_r == ST_NOP);

    // Field decode
    assign dec.opcode      = instr[13:8];
    assign dec.dest_file   = instr[DEST_BIT];
    assign dec.faddr       = instr[FADDR_LSB +: FADDR_W];
    assign dec.bit_sel     = instr[BITSEL_LSB +: BIT_SEL_W];
    assign dec.jump_target = instr[JUMP_LSB +: JUMP_W];
    assign dest_acc        = ~dec.dest_file;

    assign is_com   = (dec.opcode == OP_COMPLEMENT);
    assign is_dec   = (dec.opcode == OP_DECREMENT);
    assign is_inc   = (dec.opcode == OP_INCREMENT);
    assign is_decsz = (dec.opcode == OP_DEC_SKIP);
    assign is_incsz = (dec.opcode == OP_INC_SKIP);
    assign is_jump  = (instr[13:11] == OP_LONG_JUMP);

    // Operand fetched during phase 0, stable by phase 3
    file_ram u_file_ram (
        .ref_clk (ref_clk),
        .wr_en   (res.f_write),
        .wr_addr (dec.faddr),
        .wr_data (res.result),
        .rd_addr (dec.faddr),
        .rd_data (operand)
    );

    // Arithmetic and result routing
    assign com_val     = ~operand;
    assign dec_val     = operand - 8'h01;
    assign inc_val     = operand + 8'h01;
    assign alu_out     = is_com                ? com_val
                       : (is_dec || is_decsz) ? dec_val
                       : (is_inc || is_incsz) ? inc_val
                       : operand;
    assign res.result  = alu_out;

    assign result_zero = (alu_out == 8'h00);
    wire   flag_op     = is_com | is_dec | is_inc;
    wire   skip_op     = is_decsz | is_incsz;
    wire   byte_op     = flag_op | skip_op;
    // Words in a flushed cycle change nothing
    wire   do_exec     = exec_strobe & in_fetch;
    assign res.f_write = do_exec & byte_op & dec.dest_file;
    assign res.w_write = do_exec & byte_op & dest_acc;
    // Skip variants leave status alone
    assign res.z_write = do_exec & flag_op;
    assign res.z_value = result_zero;
    assign take_skip   = skip_op & result_zero;

    // Candidate program counter values
    assign jump_pc = {pc_upper_page_latch[PAGE_LO +: 2],
                      dec.jump_target};
    assign step_pc = pc_r + 13'h0001;
    assign skip_pc = pc_r + 13'h0002;

    // Next PC and state
    always_comb begin
        pc_nxt    = pc_r;
        state_nxt = state_r;
        if (exec_strobe) begin
            case (state_r)
                ST_FETCH: begin
                    if (is_jump) begin
                        pc_nxt    = jump_pc;
                        state_nxt = ST_NOP;
                    end else if (take_skip) begin
                        pc_nxt    = skip_pc;
                        state_nxt = ST_NOP;
                    end else begin
                        pc_nxt    = step_pc;
                    end
                end
                ST_NOP: begin
                    state_nxt = ST_FETCH;
                end
                default: begin
                    state_nxt = ST_FETCH;
                end
            endcase
        end
    end

    // Reset leaves the file RAM as it was
    always_ff @(posedge ref_clk) begin
        if (reset) begin
            phase_r <= PHASE_RESET;
        end else begin
            phase_r <= phase_nxt;
        end
    end

    always_ff @(posedge ref_clk) begin
        if (reset) begin
            state_r <= ST_FETCH;
        end else begin
            state_r <= state_nxt;
        end
    end

    always_ff @(posedge ref_clk) begin
        if (reset) begin
            pc_r <= PC_RESET;
        end else begin
            pc_r <= pc_nxt;
        end
    end

    always_ff @(posedge ref_clk) begin
        if (reset) begin
            acc_r <= W_RESET;
        end else if (res.w_write) begin
            acc_r <= res.result;
        end
    end

    always_ff @(posedge ref_clk) begin
        if (reset) begin
            zero_r <= 1'b0;
        end else if (res.z_write) begin
            zero_r <= res.z_value;
        end
    end

    // One match per bit position picks the bit-select operand
    for (genvar gi = 0; gi < DATA_W; gi++) begin : g_bit_pick
        assign bit_hit[gi] = operand[gi]
                           & (dec.bit_sel == BIT_SEL_W'(gi));
    end

    assign pc           = pc_r;
    assign acc          = acc_r;
    assign zero_flag    = zero_r;
    assign phase        = phase_r;
    assign cycle_end    = exec_strobe;
    assign nop_cycle    = in_nop;
    assign unknown_op   = ~(byte_op | is_jump);
    assign sel_bit      = |bit_hit;
    assign file_rd_data = operand;
endmodule
`default_nettype wire

/* bench/byte_op_monitor.sv */
// Checker for the byte-op execute unit: phase, pc and flush sequencing.
// Assumes it is bound to byte_op_execute_unit and sees its ports only.
`timescale 1ns/1ps
`default_nettype none
module byte_op_monitor
    import byte_op_pkg::*;
(
    input wire logic               ref_clk,             // Core clock
    input wire logic               reset,               // Sync reset
    input wire logic [INSTR_W-1:0] instr,               // Instruction
    input wire logic [7:0]         pc_upper_page_latch, // Page latch
    input wire logic [PC_W-1:0]    pc,                  // Program counter
    input wire logic [DATA_W-1:0]  acc,                 // Accumulator
    input wire logic               zero_flag,           // Zero status
    input wire logic [1:0]         phase,               // Oscillator phase
    input wire logic               cycle_end,           // Last phase
    input wire logic               nop_cycle            // Flushed cycle
);
    default clocking cb @(posedge ref_clk); endclocking
    default disable iff (reset);
    wire            run_now = cycle_end && !nop_cycle;
    wire            is_jump = instr[13:11] == OP_LONG_JUMP;
    wire            is_skip = instr[13:8] inside {OP_DEC_SKIP, OP_INC_SKIP};
    wire [PC_W-1:0] jump_pc = {pc_upper_page_latch[4:3], instr[10:0]};
    sequence exec_jump; run_now && is_jump; endsequence
    sequence flush_cycle; nop_cycle [*4] ##1 !nop_cycle; endsequence

    a_phase_step:
        assert property (!$past(reset) |-> phase == $past(phase) + 2'h1)
        else $error("phase did not step");
    a_end_flag: assert property (cycle_end == (phase == 2'h3))
        else $error("cycle end not in last phase");
    a_mid_hold: assert property (!cycle_end |=> $stable(pc))
        else $error("pc moved inside a cycle");
    a_plain_step:
        assert property (run_now && !is_jump && !is_skip |=> pc == $past(pc) + 1'b1)
        else $error("pc did not advance by one");
    a_nop_hold:
        assert property (cycle_end && nop_cycle |=> $stable(acc) && !nop_cycle)
        else $error("flushed word was executed");
    a_flush_len: assert property ($rose(nop_cycle) |-> flush_cycle)
        else $error("flush cycle length wrong");
    a_jump_pc:
        assert property (exec_jump |=> pc == $past(jump_pc) && $stable(zero_flag))
        else $error("jump target or status wrong");
    a_skip_status:
        assert property (run_now && is_skip |=> $stable(zero_flag))
        else $error("skip changed zero status");
endmodule

bind byte_op_execute_unit byte_op_monitor u_mon (.ref_clk(ref_clk),
    .reset(reset), .instr(instr), .pc_upper_page_latch(pc_upper_page_latch),
    .pc(pc), .acc(acc), .zero_flag(zero_flag), .phase(phase),
    .cycle_end(cycle_end), .nop_cycle(nop_cycle));
`default_nettype wire

/* bench/byte_op_execute_unit_bench.sv */
// Testbench for the byte-op execute unit: runs instruction words and
// checks pc, acc, zero and flush cycles. Assumes the checker is bound.
`timescale 1ns/1ps
`default_nettype none
module byte_op_execute_unit_bench
    import byte_op_pkg::*;
;
    logic               ref_clk = 1'b0;
    logic               reset = 1'b1;
    logic [INSTR_W-1:0] instr = '0;
    logic [7:0]         latch = 8'h00;
    logic [PC_W-1:0]    pc;
    logic [DATA_W-1:0]  acc, file_rd_data, wv;
    logic [1:0]         phase;
    logic               zero_flag, cycle_end, nop_cycle, unknown_op, sel_bit;
    logic [6:0]         wa;
    logic               wok = 1'b0;
    logic [5:0]         ops [5] = '{OP_COMPLEMENT, OP_DECREMENT, OP_INCREMENT,
                                    OP_DEC_SKIP, OP_INC_SKIP};
    int                 error_cnt = 0;
    int                 checks_done = 0;
    always #4 ref_clk = ~ref_clk;
    byte_op_execute_unit u_dut (.ref_clk(ref_clk), .reset(reset),
        .instr(instr), .pc_upper_page_latch(latch), .pc(pc), .acc(acc),
        .zero_flag(zero_flag), .phase(phase), .cycle_end(cycle_end),
        .nop_cycle(nop_cycle), .unknown_op(unknown_op), .sel_bit(sel_bit),
        .file_rd_data(file_rd_data));

    task automatic check(string nm, logic [15:0] seen, logic [15:0] exp);
        checks_done++;
        if (seen !== exp || $isunknown(seen)) begin
            error_cnt++;
            $display("[FAIL] %s expected %h seen %h", nm, exp, seen);
        end
    endtask

    task automatic final_report();
        $display("checks %0d mismatches %0d", checks_done, error_cnt);
        if (error_cnt == 0 && checks_done > 0) begin
            $display("*** PASS ***");
        end else begin
            $display("*** FAIL ***");
        end
        $finish;
    endtask

    // Lands mid-cycle when called after a run
    task automatic do_reset();
        @(posedge ref_clk);
        #1 reset = 1'b1;
        repeat (10) @(posedge ref_clk);
        #1 reset = 1'b0;
        check("pc", 16'(pc), 16'h0000);
        check("acc", 16'(acc), 16'h0000);
        check("zero", 16'(zero_flag), 16'h0000);
        check("phase", 16'(phase), 16'h0000);
        check("nop", 16'(nop_cycle), 16'h0000);
        wok = 1'b0;
    endtask

    // Holds one word for a full cycle, then checks the executing edge
    task automatic run(logic [INSTR_W-1:0] w);
        logic [PC_W-1:0]   p0, e_pc;
        logic [DATA_W-1:0] a0, opnd, res;
        logic              z0, n0, jmp, skp, dat, tk, unk;
        int                n;
        n = 0;
        while (phase !== 2'h0 && n < 8) begin
            @(posedge ref_clk);
            #1 n++;
        end
        if (n == 8) begin
            error_cnt++;
            final_report();
        end
        instr = w;
        repeat (3) @(posedge ref_clk);
        #1 opnd = file_rd_data;
        p0 = pc;
        a0 = acc;
        z0 = zero_flag;
        n0 = nop_cycle;
        check("cycle_end", 16'(cycle_end), 16'h0001);
        check("sel_bit", 16'(sel_bit), 16'(opnd[w[9:7]]));
        if (wok && w[6:0] == wa) check("file", 16'(opnd), 16'(wv));
        dat = !n0 && (w[13:8] inside {ops});
        res = (w[13:8] == OP_COMPLEMENT) ? ~opnd
            : (w[13:8] inside {OP_DECREMENT, OP_DEC_SKIP}) ? opnd - 8'h01
            : opnd + 8'h01;
        jmp = !n0 && w[13:11] == OP_LONG_JUMP;
        skp = !n0 && (w[13:8] inside {OP_DEC_SKIP, OP_INC_SKIP});
        tk = skp && res == 8'h00;
        unk = !(w[13:8] inside {ops}) && w[13:11] != OP_LONG_JUMP;
        e_pc = n0 ? p0 : jmp ? {latch[4:3], w[10:0]} : p0 + (tk ? 13'h2 : 13'h1);
        @(posedge ref_clk);
        #1 check("pc", 16'(pc), 16'(e_pc));
        check("acc", 16'(acc), 16'((dat && !w[7]) ? res : a0));
        check("zero", 16'(zero_flag), 16'((dat && !skp) ? res == 8'h00 : z0));
        check("nop", 16'(nop_cycle), 16'(jmp || tk));
        check("unknown_op", 16'(unknown_op), 16'(unk));
        if (dat && w[7]) begin
            wa = w[6:0];
            wv = res;
            wok = 1'b1;
        end
    endtask

    initial begin
        do_reset();
        // File RAM has no reset: seed it so every operand is known
        for (int a = 0; a < FILE_DEPTH; a++) begin
            u_dut.u_file_ram.mem[a] = 8'(a);
        end
        u_dut.u_file_ram.mem[7'h7F] = 8'h01;
        u_dut.u_file_ram.mem[7'h00] = 8'hFF;
        for (int pg = 0; pg < 4; pg++) begin
            latch = {3'h7, 2'(pg), 3'h7};
            run({OP_LONG_JUMP, 11'h7FF});
            run({OP_INCREMENT, 8'h85});
            run({OP_LONG_JUMP, 11'h000});
            run({OP_LONG_JUMP, 11'h2AA});
        end
        $display("test jump done");
        // Seeded words give zero results and taken skips on both routes
        foreach (ops[i]) for (int d = 0; d < 2; d++) begin
            run({ops[i], 1'(d), 7'h7F});
            run({ops[i], 1'(d), 7'h7F});
            run({ops[i], 1'(d), 7'h00});
        end
        $display("test byte ops done");
        do_reset();
        run(14'h0000);
        run({OP_LONG_JUMP, 11'h123});
        $display("test reset done");
        final_report();
    end
endmodule
`default_nettype wire
